// >>> common/mcfg_pkg.sv
// Package for the module configuration and shutdown control block.
// Assumes a single pclk domain and an APB register port.
package mcfg_pkg;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;

    localparam int CTRL_DISP_ON   = 0;
    localparam int CTRL_CLR_LATCH = 1;
    localparam int CTRL_CAL_REQ   = 2;
    localparam int CTRL_PWD_OK    = 3;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    localparam logic [1:0] RI_OFF   = 2'b00;
    localparam logic [1:0] RI_LIVE  = 2'b10;
    localparam logic [1:0] RI_LATCH = 2'b11;

    localparam logic [1:0] CAL_INHIBIT = 2'b00;
    localparam logic [1:0] CAL_FACTORY = 2'b10;
    localparam logic [1:0] CAL_NORMAL  = 2'b11;

    typedef enum logic [1:0]
    {
        MCFG_START = 2'b00,
        MCFG_SAMPLE = 2'b01,
        MCFG_RUN = 2'b11
    } mcfg_phase_t;

    typedef struct packed
    {
        logic [1:0] ri_mode;
        logic       disp_en;
        logic [1:0] cal_mode;
        logic       pon_default;
        logic [1:0] service;
    } mcfg_cfg_t;

    typedef struct packed
    {
        mcfg_phase_t phase;
        mcfg_cfg_t   cfg;
        logic        sync1;
        logic        sync2;
        logic        latched;
        logic        disp_sw;
        logic        pwd_ok;
        logic        cal_active;
        logic        factory_restore;
        logic        boot_recall;
        logic        boot_default;
        logic        out_off;
        logic [31:0] prdata;
    } mcfg_state_t;

endpackage : mcfg_pkg

// >>> hdl/mcfg_top.sv
// Configuration switch decoder and output shutdown control for a power module.
// Assumes the shutdown line and switches are asynchronous, pclk at 50 MHz.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Contact closure to ground counts as shutdown
// - Switches 1,2 select off, live, latching
// - Disabled mode leaves output untouched
// - Latching mode shuts and stays off
// - Latched shutdown cleared only by software
// - Live mode shuts only while line low
// - Live mode restores when line returns high
// - Switch 3 low blanks indicators, annunciators untouched
// - Enabled switch lets software toggle indicators
// - Switches 4,5 select inhibit, factory, normal
// - Normal calibration needs valid password
// - Factory mode restores constants without password
// - Switch 6 high boots default reset state
// - Switch 6 low recalls saved slot zero
module mcfg_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        remote_shutdown_line,
    input  wire logic [7:0]  config_switch,
    output logic             output_shutdown,
    output logic             indicators_on,
    output logic             annunciators_on,
    output logic             cal_enable,
    output logic             factory_restore,
    output logic             recall_slot_zero_state,
    output logic             default_reset_state
);

    mcfg_pkg::mcfg_state_t s;
    mcfg_pkg::mcfg_state_t next_s;

    logic wr;
    logic rd;
    logic addr_ok;
    logic ri_low;
    logic ctrl_wr;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == mcfg_pkg::ADDR_CTRL) || (a == mcfg_pkg::ADDR_STATUS)
                   || (a == mcfg_pkg::ADDR_CONFIG);
    endfunction : addr_hit

    assign addr_ok = addr_hit(paddr);
    assign wr      = psel && penable && pwrite;
    assign ctrl_wr = wr && paddr == mcfg_pkg::ADDR_CTRL;
    assign rd      = psel && !penable && !pwrite;
    // The line is low-true; a grounded contact reads the same as a mainframe request.
    assign ri_low  = !s.sync2;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_s       = s;
        next_s.sync1 = remote_shutdown_line;
        next_s.sync2 = s.sync1;
        case (s.phase)
            mcfg_pkg::MCFG_START:
            begin
                next_s.phase = mcfg_pkg::MCFG_SAMPLE;
            end
            mcfg_pkg::MCFG_SAMPLE:
            begin
                // Sampled once so a switch nudged in service cannot change modes live.
                next_s.cfg.ri_mode     = config_switch[1:0];
                next_s.cfg.disp_en     = config_switch[2];
                next_s.cfg.cal_mode    = config_switch[4:3];
                next_s.cfg.pon_default = config_switch[5];
                next_s.cfg.service     = config_switch[7:6];
                next_s.boot_default    = config_switch[5];
                next_s.boot_recall     = !config_switch[5];
                next_s.phase           = mcfg_pkg::MCFG_RUN;
            end
            mcfg_pkg::MCFG_RUN:
            begin
                next_s.boot_default = 1'b0;
                next_s.boot_recall  = 1'b0;
            end
            default:
            begin
                next_s.phase = mcfg_pkg::MCFG_START;
            end
        endcase

        next_s.factory_restore = 1'b0;
        if (wr && paddr == mcfg_pkg::ADDR_CTRL)
        begin
            next_s.disp_sw = pwdata[mcfg_pkg::CTRL_DISP_ON];
            if (pwdata[mcfg_pkg::CTRL_CLR_LATCH])
            begin
                next_s.latched = 1'b0;
            end
            if (pwdata[mcfg_pkg::CTRL_PWD_OK])
            begin
                next_s.pwd_ok = 1'b1;
            end
            if (pwdata[mcfg_pkg::CTRL_CAL_REQ])
            begin
                if (s.cfg.cal_mode == mcfg_pkg::CAL_NORMAL)
                begin
                    next_s.cal_active = s.pwd_ok;
                end
                else if (s.cfg.cal_mode == mcfg_pkg::CAL_FACTORY)
                begin
                    next_s.factory_restore = 1'b1;
                end
            end
        end
        if (s.cfg.cal_mode != mcfg_pkg::CAL_NORMAL)
        begin
            next_s.cal_active = 1'b0;
        end

        // Setting the latch wins over a software clear in the same cycle.
        if (s.phase == mcfg_pkg::MCFG_RUN && s.cfg.ri_mode == mcfg_pkg::RI_LATCH
            && ri_low)
        begin
            next_s.latched = 1'b1;
        end
        if (s.cfg.ri_mode != mcfg_pkg::RI_LATCH)
        begin
            next_s.latched = 1'b0;
        end

        case (s.cfg.ri_mode)
            mcfg_pkg::RI_LATCH: next_s.out_off = next_s.latched;
            mcfg_pkg::RI_LIVE:  next_s.out_off = ri_low;
            default:            next_s.out_off = 1'b0;
        endcase
        if (s.phase != mcfg_pkg::MCFG_RUN)
        begin
            next_s.out_off = 1'b0;
        end

        next_s.prdata = 32'h0000_0000;
        if (rd)
        begin
            case (paddr)
                mcfg_pkg::ADDR_CTRL:   next_s.prdata = {28'h000_0000, s.pwd_ok, 2'b00,
                                                        s.disp_sw};
                mcfg_pkg::ADDR_STATUS: next_s.prdata = {27'h000_0000, s.cal_active,
                                                        s.sync2, s.latched, s.out_off,
                                                        s.phase == mcfg_pkg::MCFG_RUN};
                mcfg_pkg::ADDR_CONFIG: next_s.prdata = {24'h00_0000, s.cfg};
                default:               next_s.prdata = 32'h0000_0000;
            endcase
        end
        else if (psel && penable)
        begin
            next_s.prdata = s.prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s         <= '0;
            s.sync1   <= 1'b1;
            s.sync2   <= 1'b1;
            s.disp_sw <= mcfg_pkg::CTRL_RESET[mcfg_pkg::CTRL_DISP_ON];
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata                 = s.prdata;
    assign pready                 = 1'b1;
    assign pslverr                = psel && penable && !addr_ok;
    assign output_shutdown        = s.out_off;
    assign indicators_on          = s.cfg.disp_en && s.disp_sw;
    assign annunciators_on        = 1'b1;
    assign cal_enable             = s.cal_active;
    assign factory_restore        = s.factory_restore;
    assign recall_slot_zero_state = s.boot_recall;
    assign default_reset_state    = s.boot_default;

    ////////////////////////////////////////////////////////////////////////////
    // Remote shutdown response; every check here sits behind the two-flop synchroniser.
    live_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_RUN && s.cfg.ri_mode == mcfg_pkg::RI_LIVE
        |=> output_shutdown == !$past(s.sync2))
        else $error("live shutdown wrong");
    live_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_RUN && s.cfg.ri_mode == mcfg_pkg::RI_LIVE
        && $rose(s.sync2) |=> !output_shutdown)
        else $error("no live restore");
    live_unlatched_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.cfg.ri_mode == mcfg_pkg::RI_LIVE
        |-> !s.latched)
        else $error("live mode latched");
    off_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.cfg.ri_mode == mcfg_pkg::RI_OFF
        |-> !output_shutdown)
        else $error("disabled mode shut output");
    off_unlatched_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.cfg.ri_mode == mcfg_pkg::RI_OFF
        |-> !s.latched)
        else $error("disabled mode latched");
    latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_RUN && s.cfg.ri_mode == mcfg_pkg::RI_LATCH && !s.sync2
        |=> output_shutdown)
        else $error("latch did not shut");
    latch_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s.latched)
        |-> !$past(s.sync2))
        else $error("latch set without request");
    latch_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.latched && !(ctrl_wr && pwdata[mcfg_pkg::CTRL_CLR_LATCH])
        && s.cfg.ri_mode == mcfg_pkg::RI_LATCH |=> s.latched)
        else $error("latch dropped alone");
    latch_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_RUN && s.cfg.ri_mode == mcfg_pkg::RI_LATCH && s.sync2
        && ctrl_wr && pwdata[mcfg_pkg::CTRL_CLR_LATCH] |=> !output_shutdown)
        else $error("latch clear ignored");
    run_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase != mcfg_pkg::MCFG_RUN
        |=> !output_shutdown)
        else $error("shutdown before switch sample");

    // Indicators; the annunciators stay lit whatever the display switch says.
    disp_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s.cfg.disp_en
        |-> !indicators_on && annunciators_on)
        else $error("indicators not blanked");
    disp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.cfg.disp_en
        |-> indicators_on == s.disp_sw && annunciators_on)
        else $error("indicators ignore software");
    disp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr
        |=> s.disp_sw == $past(pwdata[mcfg_pkg::CTRL_DISP_ON]))
        else $error("display write lost");

    // Calibration grants and the one-cycle factory restore pulse.
    cal_pwd_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cal_enable)
        |-> $past(s.pwd_ok) && s.cfg.cal_mode == mcfg_pkg::CAL_NORMAL)
        else $error("calibration without password");
    cal_grant_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr && pwdata[mcfg_pkg::CTRL_CAL_REQ] && s.pwd_ok
        && s.cfg.cal_mode == mcfg_pkg::CAL_NORMAL |=> cal_enable)
        else $error("calibration refused");
    cal_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        cal_enable
        |-> s.cfg.cal_mode == mcfg_pkg::CAL_NORMAL)
        else $error("calibration outside normal mode");
    factory_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr && pwdata[mcfg_pkg::CTRL_CAL_REQ]
        && s.cfg.cal_mode == mcfg_pkg::CAL_FACTORY |=> factory_restore)
        else $error("factory restore missing");
    factory_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        factory_restore
        |-> s.cfg.cal_mode == mcfg_pkg::CAL_FACTORY && !cal_enable)
        else $error("factory restore in wrong mode");
    factory_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        factory_restore
        |=> !factory_restore)
        else $error("factory restore held");

    // Power-on choice and switch sampling; a later switch change must not leak in.
    boot_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_SAMPLE |=> recall_slot_zero_state == !s.cfg.pon_default
        && default_reset_state == s.cfg.pon_default)
        else $error("boot select wrong");
    boot_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_RUN && $past(s.phase) == mcfg_pkg::MCFG_RUN
        |-> !recall_slot_zero_state && !default_reset_state)
        else $error("boot pulse repeated");
    cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_RUN
        |=> $stable(s.cfg))
        else $error("switches sampled twice");
    phase_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        s.phase == mcfg_pkg::MCFG_SAMPLE || s.phase == mcfg_pkg::MCFG_RUN
        |=> s.phase == mcfg_pkg::MCFG_RUN)
        else $error("sample phase left wrongly");
    sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1
        |-> ##2 s.sync2 == $past(remote_shutdown_line, 2))
        else $error("sync chain wrong");

endmodule : mcfg_top

`default_nettype wire

// >>> dv/mcfg_mainframe_model.sv
// Mainframe side of the shared shutdown line, with an external contact.
// Assumes the bench drives the mainframe request and the contact level.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mcfg_mainframe_model
(
    input  wire logic host_request,
    input  wire logic contact_closed,
    output logic      remote_shutdown_line
);
    // The pull-up keeps the line high; either party may short it to ground.
    assign remote_shutdown_line = !(host_request || contact_closed);
endmodule : mcfg_mainframe_model
`default_nettype wire

// >>> dv/mcfg_top_test.sv
// Self-checking bench for the configuration and shutdown block.
// Assumes the mainframe model and the block package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module mcfg_top_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0]  config_switch = 8'hff;
    logic        host_request = 1'b0;
    logic        contact_closed = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, err, remote_shutdown_line, output_shutdown;
    logic        indicators_on, annunciators_on, cal_enable, factory_restore;
    logic        recall_slot_zero_state, default_reset_state;
    int          n_errors = 0;
    int          tests_run = 0;

    always #10 pclk = ~pclk;

    mcfg_mainframe_model mainframe (.host_request, .contact_closed, .remote_shutdown_line);
    mcfg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .remote_shutdown_line, .config_switch, .output_shutdown,
        .indicators_on, .annunciators_on, .cal_enable, .factory_restore,
        .recall_slot_zero_state, .default_reset_state);
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Switches move after the boot sample to show that the block ignores them.
    task automatic boot(input logic [7:0] sw);
        logic [31:0] pr, pd;
        pr = 0;
        pd = 0;
        @(posedge pclk);
        config_switch <= sw;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6)
        begin
            @(negedge pclk);
            pr += recall_slot_zero_state;
            pd += default_reset_state;
        end
        @(posedge pclk);
        config_switch <= sw ^ 8'h3f;
        check("recall pulses", {31'h0000_0000, !sw[5]}, pr);
        check("default pulses", {31'h0000_0000, sw[5]}, pd);
        apb(1'b0, mcfg_pkg::ADDR_CONFIG, 32'h0000_0000);
        check("config", {24'h00_0000, sw[1:0], sw[2], sw[4:3], sw[5], sw[7:6]}, rd);
    endtask : boot

    task automatic shut(input logic req, input logic cont, input logic exp, input string what);
        @(posedge pclk);
        host_request <= req;
        contact_closed <= cont;
        repeat (6) @(negedge pclk);
        check(what, {31'h0000_0000, exp}, {31'h0000_0000, output_shutdown});
    endtask : shut

    task automatic disp(input logic en);
        apb(1'b1, mcfg_pkg::ADDR_CTRL, 32'h0000_0001);
        @(negedge pclk);
        check("indicators on", {31'h0000_0000, en}, {31'h0000_0000, indicators_on});
        apb(1'b1, mcfg_pkg::ADDR_CTRL, 32'h0000_0000);
        @(negedge pclk);
        check("indicators off", 32'h0000_0000, {31'h0000_0000, indicators_on});
        check("annunciators", 32'h0000_0001, {31'h0000_0000, annunciators_on});
    endtask : disp

    task automatic cal(input logic pwd, input logic exp_en, input logic [31:0] exp_fr);
        logic [31:0] fr;
        fr = 0;
        if (pwd)
            apb(1'b1, mcfg_pkg::ADDR_CTRL, 32'h0000_0008);
        apb(1'b1, mcfg_pkg::ADDR_CTRL, 32'h0000_0004);
        repeat (6)
        begin
            @(negedge pclk);
            fr += factory_restore;
        end
        check("cal enable", {31'h0000_0000, exp_en}, {31'h0000_0000, cal_enable});
        check("factory pulses", exp_fr, fr);
    endtask : cal

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        boot(8'hff);
        shut(1'b1, 1'b0, 1'b1, "latch low");
        apb(1'b1, mcfg_pkg::ADDR_CTRL, 32'h0000_0002);
        shut(1'b0, 1'b0, 1'b1, "latch kept");
        apb(1'b1, mcfg_pkg::ADDR_CTRL, 32'h0000_0002);
        shut(1'b0, 1'b0, 1'b0, "latch cleared");
        disp(1'b1);
        cal(1'b0, 1'b0, 32'h0000_0000);
        cal(1'b1, 1'b1, 32'h0000_0000);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check("unmapped data", 32'h0000_0000, rd);
        check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
        check("ready", 32'h0000_0001, {31'h0000_0000, pready});
        boot(8'hf6);
        shut(1'b0, 1'b1, 1'b1, "live closure");
        shut(1'b0, 1'b0, 1'b0, "live restore");
        shut(1'b1, 1'b0, 1'b1, "live low");
        shut(1'b0, 1'b0, 1'b0, "live high");
        cal(1'b0, 1'b0, 32'h0000_0001);
        boot(8'hc0);
        shut(1'b1, 1'b0, 1'b0, "ignored low");
        shut(1'b0, 1'b1, 1'b0, "ignored closure");
        disp(1'b0);
        cal(1'b1, 1'b0, 32'h0000_0000);
        end_of_test();
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
endmodule : mcfg_top_test
`default_nettype wire
